/* File: ldsd_params.svh */
// offsets, field positions, reset values for the ldo sleep and discharge register bank
`ifndef LDSD_PARAMS_SVH
`define LDSD_PARAMS_SVH
// printed offsets are not multiples of four: kept as indices, byte address is index * 4
`define LDSD_IDX_LDO_C_CONTROL       8'h29
`define LDSD_IDX_DISCHARGE_A         8'h40
`define LDSD_IDX_DISCHARGE_B         8'h41
// field positions of the third ldo control register
`define LDSD_SLEEP_SEL_HI            5
`define LDSD_SLEEP_SEL_LO            4
`define LDSD_RSVD_HI                 3
`define LDSD_RSVD_LO                 1
`define LDSD_FORCE_OFF_N_BIT         0
// reset values
`define LDSD_LDO_C_RESET             8'h0c
`define LDSD_DISCH_A_RESET           8'h55
`define LDSD_DISCH_B_RESET           8'h55
`define LDSD_RO_MASK_LDO_C           8'h3f
`endif

/* File: ldsd_pkg.sv */
// types for the ldo sleep and discharge register bank
`default_nettype none
package ldsd_pkg;
    typedef enum logic [1:0] {
        LDSD_SLP_OFF  = 2'h0,
        LDSD_SLP_RSV1 = 2'h1,
        LDSD_SLP_RSV2 = 2'h2,
        LDSD_SLP_ON   = 2'h3
    } ldsd_sleep_sel_e;

    typedef enum logic [1:0] {
        LDSD_DIS_NONE = 2'h0,
        LDSD_DIS_100  = 2'h1,
        LDSD_DIS_200  = 2'h2,
        LDSD_DIS_500  = 2'h3
    } ldsd_disch_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ldsd_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ldsd_apb_rsp_s;

    typedef struct packed {
        logic [7:0]  ldo_c_r;
        logic [7:0]  disch_a_r;
        logic [7:0]  disch_b_r;
        logic [31:0] prdata_r;
        logic        pslverr_r;
        logic [2:0]  slp_a_sync_r;
        logic [2:0]  slp_b_sync_r;
        logic        slp_a_r;
        logic        slp_b_r;
        logic        use_sleep_r;
        logic        ldo_c_on_r;
    } ldsd_state_s;
endpackage : ldsd_pkg
`default_nettype wire

/* File: ldsd_regs.sv */
// register bank: third ldo control and discharge selection over apb
//
// Overview of operation
// - sleep select 00: rail always uses normal voltage code, sleep pin ignored.
// - sleep select 11: sleep voltage code while assigned sleep pin is low.
// - sleep pin choice is factory fixed, not register controlled.
// - bit zero low forces the rail off regardless of control pins.
// - discharge field codes: none, 100, 200, 500 ohms.
// - discharge field cleared to 00 while its buck is enabled; ldo c clears b 1:0 or 3:2 only for clear select 1 or 2.
// - discharge register a holds buck four..one in 7:6,5:4,3:2,1:0.
`include "ldsd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ldsd_regs #(
    parameter bit SLEEP_PIN_B = 1'b0 // factory strap, fixed per build
) (
    input  wire logic                  mclk_i,
    input  wire logic                  reset_n_i,
    input  wire ldsd_pkg::ldsd_apb_req_s apb_req_i,
    output ldsd_pkg::ldsd_apb_rsp_s    apb_rsp_o,
    input  wire logic                  sleep_pin_a_i,
    input  wire logic                  sleep_pin_b_i,
    input  wire logic                  ldo_c_pin_enable_i,
    input  wire logic [3:0]            buck_enabled_i,
    input  wire logic [1:0]            ldo_c_disch_clear_sel_i,
    output logic                       ldo_c_enable_o,
    output logic                       ldo_c_use_sleep_code_o,
    output ldsd_pkg::ldsd_disch_e      buck_one_discharge_sel_o,
    output ldsd_pkg::ldsd_disch_e      buck_two_discharge_sel_o,
    output ldsd_pkg::ldsd_disch_e      buck_three_discharge_sel_o,
    output ldsd_pkg::ldsd_disch_e      buck_four_discharge_sel_o,
    output logic [7:0]                 discharge_b_o
);
    import ldsd_pkg::*;

    ldsd_state_s st_r;
    ldsd_state_s st_nxt;
    logic        wr_en;
    logic        rd_en;
    logic [9:0]  idx;
    logic        hit;
    logic [7:0]  rd_byte;
    logic        sleep_req;

    ////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, unaligned or unmapped raise pslverr
    assign idx   = apb_req_i.paddr[11:2];
    assign wr_en = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
    assign rd_en = apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite;
    assign hit   = (apb_req_i.paddr[1:0] == 2'h0) &&
                   ((idx == {2'h0, `LDSD_IDX_LDO_C_CONTROL}) ||
                    (idx == {2'h0, `LDSD_IDX_DISCHARGE_A}) ||
                    (idx == {2'h0, `LDSD_IDX_DISCHARGE_B}));

    always_comb begin
        rd_byte = 8'h00;
        if (idx == {2'h0, `LDSD_IDX_LDO_C_CONTROL}) begin
            rd_byte = st_r.ldo_c_r & `LDSD_RO_MASK_LDO_C;
        end else if (idx == {2'h0, `LDSD_IDX_DISCHARGE_A}) begin
            rd_byte = st_r.disch_a_r;
        end else if (idx == {2'h0, `LDSD_IDX_DISCHARGE_B}) begin
            rd_byte = st_r.disch_b_r;
        end
    end

    // pin selected by strap, never by software
    assign sleep_req = SLEEP_PIN_B ? st_r.slp_b_r : st_r.slp_a_r;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_nxt = st_r;
        // three flops, change accepted when second and third agree
        st_nxt.slp_a_sync_r = {st_r.slp_a_sync_r[1:0], sleep_pin_a_i};
        st_nxt.slp_b_sync_r = {st_r.slp_b_sync_r[1:0], sleep_pin_b_i};
        if (st_r.slp_a_sync_r[2] == st_r.slp_a_sync_r[1]) begin
            st_nxt.slp_a_r = st_r.slp_a_sync_r[2];
        end
        if (st_r.slp_b_sync_r[2] == st_r.slp_b_sync_r[1]) begin
            st_nxt.slp_b_r = st_r.slp_b_sync_r[2];
        end
        if (rd_en) begin
            // refused reads return zero, not the aliased register
            st_nxt.prdata_r  = hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            st_nxt.pslverr_r = !hit;
        end else if (apb_req_i.psel && !apb_req_i.penable) begin
            st_nxt.prdata_r  = 32'h0000_0000;
            st_nxt.pslverr_r = !hit;
        end
        if (wr_en && hit) begin
            // reserved sleep codes and bits 3:1 stored as written; host keeps them legal
            if (idx == {2'h0, `LDSD_IDX_LDO_C_CONTROL}) begin
                st_nxt.ldo_c_r = apb_req_i.pwdata[7:0] & `LDSD_RO_MASK_LDO_C;
            end else if (idx == {2'h0, `LDSD_IDX_DISCHARGE_A}) begin
                st_nxt.disch_a_r = apb_req_i.pwdata[7:0];
            end else begin
                st_nxt.disch_b_r = apb_req_i.pwdata[7:0];
            end
        end
        // hardware clear wins over a same-cycle software write
        for (int i = 0; i < 4; i++) begin
            if (buck_enabled_i[i]) begin
                st_nxt.disch_a_r[2*i +: 2] = LDSD_DIS_NONE;
            end
        end
        if (st_r.ldo_c_on_r) begin
            case (ldo_c_disch_clear_sel_i)
                2'h1:    st_nxt.disch_b_r[1:0] = LDSD_DIS_NONE;
                2'h2:    st_nxt.disch_b_r[3:2] = LDSD_DIS_NONE;
                default: st_nxt.disch_b_r = st_nxt.disch_b_r;
            endcase
        end
        st_nxt.ldo_c_on_r = ldo_c_pin_enable_i &&
                            st_r.ldo_c_r[`LDSD_FORCE_OFF_N_BIT];
        case (st_r.ldo_c_r[`LDSD_SLEEP_SEL_HI:`LDSD_SLEEP_SEL_LO])
            LDSD_SLP_OFF: st_nxt.use_sleep_r = 1'b0;
            LDSD_SLP_ON:  st_nxt.use_sleep_r = !sleep_req;
            default:      st_nxt.use_sleep_r = 1'b0;       // reserved: stay on normal code
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r           <= '0;
            st_r.ldo_c_r   <= `LDSD_LDO_C_RESET;
            st_r.disch_a_r <= `LDSD_DISCH_A_RESET;
            st_r.disch_b_r <= `LDSD_DISCH_B_RESET;
            st_r.slp_a_sync_r <= 3'h7;
            st_r.slp_b_sync_r <= 3'h7;
            st_r.slp_a_r   <= 1'b1;
            st_r.slp_b_r   <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign apb_rsp_o.pready     = 1'b1;
    assign apb_rsp_o.pslverr    = st_r.pslverr_r;
    assign apb_rsp_o.prdata     = st_r.prdata_r;
    assign ldo_c_enable_o       = st_r.ldo_c_on_r;
    assign ldo_c_use_sleep_code_o = st_r.use_sleep_r;
    assign buck_one_discharge_sel_o   = ldsd_disch_e'(st_r.disch_a_r[1:0]);
    assign buck_two_discharge_sel_o   = ldsd_disch_e'(st_r.disch_a_r[3:2]);
    assign buck_three_discharge_sel_o = ldsd_disch_e'(st_r.disch_a_r[5:4]);
    assign buck_four_discharge_sel_o  = ldsd_disch_e'(st_r.disch_a_r[7:6]);
    assign discharge_b_o        = st_r.disch_b_r;
endmodule : ldsd_regs
`default_nettype wire

/* File: ldsd_regs_chk.sv */
// assertion checker for the ldo sleep and discharge register bank
`timescale 1ns/1ps
`default_nettype none
module ldsd_regs_chk #(
    parameter bit SLEEP_PIN_B = 1'b0
) (
    input wire logic                    mclk_i,
    input wire logic                    reset_n_i,
    input wire ldsd_pkg::ldsd_apb_req_s apb_req_i,
    input wire ldsd_pkg::ldsd_apb_rsp_s apb_rsp_o,
    input wire logic                    sleep_pin_a_i,
    input wire logic                    sleep_pin_b_i,
    input wire logic                    ldo_c_pin_enable_i,
    input wire logic [3:0]              buck_enabled_i,
    input wire logic [1:0]              ldo_c_disch_clear_sel_i,
    input wire logic                    ldo_c_enable_o,
    input wire logic                    ldo_c_use_sleep_code_o,
    input wire ldsd_pkg::ldsd_disch_e   buck_one_discharge_sel_o,
    input wire ldsd_pkg::ldsd_disch_e   buck_two_discharge_sel_o,
    input wire ldsd_pkg::ldsd_disch_e   buck_three_discharge_sel_o,
    input wire ldsd_pkg::ldsd_disch_e   buck_four_discharge_sel_o,
    input wire logic [7:0]              discharge_b_o
);
    import ldsd_pkg::*;
    logic acc, rd_c, wr_c, slp;
    assign acc = apb_req_i.psel && apb_req_i.penable;
    assign rd_c = acc && apb_req_i.paddr == 12'h0a4;
    assign wr_c = rd_c && apb_req_i.pwrite;
    // strap picks which pin counts
    assign slp = SLEEP_PIN_B ? sleep_pin_b_i : sleep_pin_a_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_en; ldo_c_enable_o |-> $past(ldo_c_pin_enable_i); endproperty
    a_en: assert property (p_en) else $error("rail on without pin");
    property p_off; wr_c && !apb_req_i.pwdata[0] |-> ##2 !ldo_c_enable_o [*2]; endproperty
    a_off: assert property (p_off) else $error("rail not forced off");
    property p_nslp; wr_c && apb_req_i.pwdata[5:4] == 2'h0 |-> ##2 !ldo_c_use_sleep_code_o [*2];
    endproperty
    a_nslp: assert property (p_nslp) else $error("sleep code while disabled");
    property p_awake; slp [*8] |-> !ldo_c_use_sleep_code_o; endproperty
    a_awake: assert property (p_awake) else $error("sleep code with pin high");
    property p_ro; rd_c && !apb_req_i.pwrite |-> apb_rsp_o.prdata[31:6] == '0; endproperty
    a_ro: assert property (p_ro) else $error("top bits not zero");
    property p_b1; buck_enabled_i[0] [*3] |-> buck_one_discharge_sel_o == LDSD_DIS_NONE;
    endproperty
    a_b1: assert property (p_b1) else $error("buck one discharge kept");
    property p_b4; buck_enabled_i[3] [*3] |-> buck_four_discharge_sel_o == LDSD_DIS_NONE;
    endproperty
    a_b4: assert property (p_b4) else $error("buck four discharge kept");
    property p_lc; (ldo_c_enable_o && ldo_c_disch_clear_sel_i == 2'h1) [*3]
        |-> discharge_b_o[1:0] == 2'h0; endproperty
    a_lc: assert property (p_lc) else $error("ldo discharge kept");
    c_slp: cover property (ldo_c_use_sleep_code_o);
    c_clr: cover property (buck_enabled_i[0] [*3]);
    c_err: cover property (acc && apb_rsp_o.pslverr);
endmodule : ldsd_regs_chk
bind ldsd_regs ldsd_regs_chk #(.SLEEP_PIN_B(SLEEP_PIN_B)) u_chk (.*);
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the ldo sleep and discharge register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, g, x) begin total_checks++; if ((g) !== (x)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", n, x, g); end end
module tb_top;
    import ldsd_pkg::*;
    typedef struct packed {logic w; logic [11:0] a; logic [7:0] d, q; logic e;} ldsd_row_s;
    logic mclk_i = 1'b0, reset_n_i = 1'b0, sleep_pin_a_i = 1'b1, sleep_pin_b_i = 1'b1;
    logic ldo_c_pin_enable_i = 1'b0, ldo_c_enable_o, ldo_c_use_sleep_code_o, e;
    logic [3:0] buck_enabled_i = 4'h0;
    logic [1:0] ldo_c_disch_clear_sel_i = 2'h0;
    logic [7:0] discharge_b_o;
    logic [31:0] q;
    int bad_count = 0, total_checks = 0;
    ldsd_apb_req_s apb_req_i = '0;
    ldsd_apb_rsp_s apb_rsp_o;
    ldsd_disch_e buck_one_discharge_sel_o, buck_two_discharge_sel_o;
    ldsd_disch_e buck_three_discharge_sel_o, buck_four_discharge_sel_o;
    wire logic [7:0] disch_a = {buck_four_discharge_sel_o, buck_three_discharge_sel_o,
        buck_two_discharge_sel_o, buck_one_discharge_sel_o};
    // reset rows first, then writes, then an unaligned read; last two are refused
    // ldo writes keep sleep select legal and bits 3:1 at 110
    ldsd_row_s rows [9] = '{'{0, 12'h0a4, 0, 8'h0c, 0}, '{0, 12'h100, 0, 8'h55, 0},
        '{0, 12'h104, 0, 8'h55, 0}, '{1, 12'h0a4, 8'hfd, 8'h3d, 0},
        '{1, 12'h0a4, 8'h0c, 8'h0c, 0}, '{1, 12'h100, 8'he4, 8'he4, 0},
        '{1, 12'h104, 8'h1b, 8'h1b, 0}, '{1, 12'h0fc, 8'h12, 0, 1}, '{0, 12'h0a5, 0, 0, 1}};
    ldsd_regs dut (.*);
    always #2 mclk_i = ~mclk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        apb_req_i <= '{1'b1, 1'b0, w, a, {24'h00_0000, d}};
        @(posedge mclk_i);
        apb_req_i.penable <= 1'b1;
        do @(posedge mclk_i); while (apb_rsp_o.pready !== 1'b1);
        q = apb_rsp_o.prdata;
        e = apb_rsp_o.pslverr;
        apb_req_i <= '0;
    endtask : apb
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : wait_n
    initial begin
        wait_n(2000);
        bad_count++;
        conclude();
    end
    initial begin
        wait_n(5);
        reset_n_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 8'h00);
            `CHK("rd", q, {24'h00_0000, rows[i].q})
            `CHK("err", e, rows[i].e)
        end
        `CHK("disch_a", disch_a, 8'he4)
        buck_enabled_i <= 4'h5;
        apb(1'b1, 12'h100, 8'hff);
        apb(1'b0, 12'h100, 8'h00);
        `CHK("clr", q, 32'h0000_00cc)
        buck_enabled_i <= 4'h0;
        ldo_c_pin_enable_i <= 1'b1;
        wait_n(3);
        `CHK("off", ldo_c_enable_o, 1'b0)
        apb(1'b1, 12'h0a4, 8'h0d);
        ldo_c_disch_clear_sel_i <= 2'h1;
        wait_n(5);
        `CHK("on", ldo_c_enable_o, 1'b1)
        `CHK("ldo_clr", discharge_b_o, 8'h18)
        apb(1'b1, 12'h0a4, 8'h3d);
        sleep_pin_a_i <= 1'b0;
        wait_n(8);
        `CHK("slp", ldo_c_use_sleep_code_o, 1'b1)
        sleep_pin_a_i <= 1'b1;
        sleep_pin_b_i <= 1'b0;
        wait_n(8);
        `CHK("pin_b", ldo_c_use_sleep_code_o, 1'b0)
        sleep_pin_a_i <= 1'b0;
        apb(1'b1, 12'h0a4, 8'h0d);
        wait_n(8);
        `CHK("slp_off", ldo_c_use_sleep_code_o, 1'b0)
        apb(1'b1, 12'h0a4, 8'h0c);
        wait_n(3);
        `CHK("forced", ldo_c_enable_o, 1'b0)
        conclude();
    end
endmodule : tb_top
`default_nettype wire
